/* File: rtl/seq_pkg.sv */
// Function
// - Sixteen entries 0..15, each with signed 32-bit target position, reset zero.
// - Mode 0 takes the target as measured from the fixed zero point.
// - Mode 1, the reset default, adds target to last target or current position.
// - Mode 2 moves at entry speed and ignores the target position.
// - Signed velocity, reset 1000; sign kept only in speed mode; clamped to max.
// - Unsigned start and brake accelerations, reset 10000; zero or excess gives max.
// - A relative entry repeats its count of 0..255 extra runs, each on its condition.
// - All repetitions of an entry finish before its follow-on entry starts.
// - Follow-on index -1..15, reset -1; -1 means no follow-on entry.
// - Condition 0, the default, launches the next run on a start signal.
// - Condition 1 launches the next run when the delay after arrival expires.
// - Condition 2 launches on a start signal or on delay expiry, whichever first.
// - Condition 3 runs straight into the next job at speed without halting.
// - Start requests count on the rising edge of the start signal only.
// - Reaction 0 ignores start edges while a move is running.
// - Reaction 1 adds the distance to the target per edge and queues follow-ons.
// - Reaction 2 sets target to actual position plus distance, without stopping.
// - With nothing running, a start edge launches the currently selected entry.
// - Per-entry delay 0..65535 ms, reset 0, used only by conditions 1 and 2.
// - Switching point selectors A and B, 0..4, reset 0; zero means none.
// - Releasing a selected index aborts any move and sequence, then starts it.
// - Selected index is binary from four select inputs weighted 1, 2, 4, 8.
package seq_pkg;
  // ************************************************************
  // Sizes and address map
  // ************************************************************
  localparam int N_ENTRY = 16;
  localparam int IDX_W = 4;
  localparam int ADDR_W = 8;
  localparam int ADDR_GLOBAL_BIT = 7;
  localparam int ADDR_IDX_LO = 3;
  localparam logic [2:0] F_POS = 3'h0;
  localparam logic [2:0] F_VEL = 3'h1;
  localparam logic [2:0] F_ACC = 3'h2;
  localparam logic [2:0] F_DEC = 3'h3;
  localparam logic [2:0] F_CFG = 3'h4;
  localparam logic [2:0] F_DLY = 3'h5;
  localparam logic [2:0] G_CTRL = 3'h0;
  localparam logic [2:0] G_STAT = 3'h1;
  localparam logic [2:0] G_TGT = 3'h2;
  localparam logic [2:0] G_SEL = 3'h3;
  // Control bits and select register
  localparam int CTRL_RELEASE = 0;
  localparam int CTRL_NEXT = 1;
  localparam int SEL_BUS_SRC = 4;
  // ************************************************************
  // Codes
  // ************************************************************
  localparam logic [1:0] ABSOLUTE_MODE = 2'h0;
  localparam logic [1:0] RELATIVE_MODE = 2'h1;
  localparam logic [1:0] MODE_SPEED = 2'h2;
  localparam logic [1:0] LAUNCH_ON_SWITCH = 2'h0;
  localparam logic [1:0] LAUNCH_AFTER_DELAY = 2'h1;
  localparam logic [1:0] LAUNCH_SWITCH_OR_DELAY = 2'h2;
  localparam logic [1:0] LAUNCH_WITHOUT_STOP = 2'h3;
  localparam logic [1:0] REACT_OFF = 2'h0;
  localparam logic [1:0] REACT_STORE = 2'h1;
  localparam logic [1:0] REACT_NEXT = 2'h2;
  localparam logic [2:0] SP_MAX = 3'h4;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int MS_NS = 1000000;
  localparam int CLK_NS = 5;
  localparam int MS_CYCLES = MS_NS / CLK_NS;
  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic [31:0] target_position;
    logic [31:0] velocity;
    logic [31:0] start_accel;
    logic [31:0] brake_accel;
    logic [1:0] move_mode;
    logic [1:0] launch_condition;
    logic [1:0] inmotion_reaction;
    logic [2:0] switch_point_a;
    logic [2:0] switch_point_b;
    logic [7:0] repeat_count;
    logic [4:0] next_index;
    logic [15:0] launch_delay;
  } entry_type;
  localparam entry_type ENTRY_RST = '{
    target_position: 32'h0, velocity: 32'h3e8, start_accel: 32'h2710,
    brake_accel: 32'h2710, move_mode: RELATIVE_MODE, launch_condition: LAUNCH_ON_SWITCH,
    inmotion_reaction: REACT_OFF, switch_point_a: 3'h0, switch_point_b: 3'h0,
    repeat_count: 8'h0, next_index: 5'h1f, launch_delay: 16'h0};
  // Config word bit positions
  localparam int CFG_MODE = 0;
  localparam int CFG_COND = 2;
  localparam int CFG_REACT = 4;
  localparam int CFG_SPA = 8;
  localparam int CFG_SPB = 12;
  localparam int CFG_REP = 16;
  localparam int CFG_NEXT = 24;
  typedef struct packed {
    logic [31:0] target;
    logic [31:0] velocity;
    logic [31:0] start_accel;
    logic [31:0] brake_accel;
    logic [1:0] move_mode;
    logic on_fly;
    logic sp_a_en;
    logic [1:0] sp_a_point;
    logic sp_b_en;
    logic [1:0] sp_b_point;
  } job_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_WAIT = 2'b11
  } state_type;
endpackage

/* File: rtl/driving_set_table_sequencer.sv */
`timescale 1ns/1ps
module driving_set_table_sequencer #(
  parameter int MS_CYCLES = seq_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [seq_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Terminal pins
  input wire logic [seq_pkg::IDX_W-1:0] entry_select_bit,
  input wire logic entry_release_input,
  input wire logic next_start_input,
  // Profile generator side
  input wire logic target_reached,
  input wire logic [31:0] actual_position,
  input wire logic [31:0] max_speed,
  input wire logic [31:0] max_accel,
  output seq_pkg::job_type job,
  output logic job_start,
  output logic job_update,
  output logic job_abort,
  output logic [seq_pkg::IDX_W-1:0] active_index
);
  localparam int MS_W = $clog2(MS_CYCLES + 1);

  // ************************************************************
  // Job builder
  // ************************************************************
  function automatic seq_pkg::job_type make_job(input seq_pkg::entry_type e,
      input logic [31:0] base, input logic fly, input logic [31:0] vmax,
      input logic [31:0] amax);
    seq_pkg::job_type j;
    logic [31:0] mag;
    logic neg;
    j = '0;
    if (e.move_mode == seq_pkg::ABSOLUTE_MODE) begin
      j.target = e.target_position;
    end else if (e.move_mode == seq_pkg::RELATIVE_MODE) begin
      j.target = base + e.target_position;
    end else begin
      j.target = 32'h0;
    end
    neg = e.velocity[31];
    mag = neg ? (32'h0 - e.velocity) : e.velocity;
    if (mag > vmax) begin
      mag = vmax;
    end
    // Sign only matters for endless travel
    j.velocity = (neg && e.move_mode == seq_pkg::MODE_SPEED) ? (32'h0 - mag) : mag;
    j.start_accel = (e.start_accel == 32'h0 || e.start_accel > amax) ?
        amax : e.start_accel;
    j.brake_accel = (e.brake_accel == 32'h0 || e.brake_accel > amax) ?
        amax : e.brake_accel;
    j.move_mode = e.move_mode;
    j.on_fly = fly;
    j.sp_a_en = e.switch_point_a != 3'h0 && e.switch_point_a <= seq_pkg::SP_MAX;
    j.sp_a_point = 2'(e.switch_point_a - 3'h1);
    j.sp_b_en = e.switch_point_b != 3'h0 && e.switch_point_b <= seq_pkg::SP_MAX;
    j.sp_b_point = 2'(e.switch_point_b - 3'h1);
    return j;
  endfunction

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [seq_pkg::IDX_W-1:0] sel_s1_ff, sel_s2_ff;
  logic rel_s1_ff, rel_s2_ff, rel_d_ff;
  logic nst_s1_ff, nst_s2_ff, nst_d_ff;

  // Two stages before use; the third stage only feeds edge detection
  always_ff @(posedge clk) begin
    if (reset) begin
      sel_s1_ff <= '0;
      sel_s2_ff <= '0;
      {rel_s1_ff, rel_s2_ff, rel_d_ff} <= 3'h0;
      {nst_s1_ff, nst_s2_ff, nst_d_ff} <= 3'h0;
    end else begin
      sel_s1_ff <= entry_select_bit;
      sel_s2_ff <= sel_s1_ff;
      {rel_s1_ff, rel_s2_ff, rel_d_ff} <= {entry_release_input, rel_s1_ff, rel_s2_ff};
      {nst_s1_ff, nst_s2_ff, nst_d_ff} <= {next_start_input, nst_s1_ff, nst_s2_ff};
    end
  end

  // ************************************************************
  // Bus slave
  // ************************************************************
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [31:0] rd_word;
  logic [4:0] sel_reg_ff;
  wire req = avs_read | avs_write;
  wire wr_en = avs_write & ack_ff;
  wire is_glb = avs_address[seq_pkg::ADDR_GLOBAL_BIT];
  wire [2:0] fld = avs_address[2:0];
  wire [seq_pkg::IDX_W-1:0] a_idx = avs_address[seq_pkg::ADDR_IDX_LO +: seq_pkg::IDX_W];
  wire bus_release = wr_en & is_glb & fld == seq_pkg::G_CTRL &
      avs_writedata[seq_pkg::CTRL_RELEASE];
  wire bus_next = wr_en & is_glb & fld == seq_pkg::G_CTRL &
      avs_writedata[seq_pkg::CTRL_NEXT];

  // One wait state: data is latched while waitrequest is high
  assign avs_waitrequest = req & ~ack_ff;
  assign avs_readdata = rdata_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0;
    end else begin
      ack_ff <= req & ~ack_ff;
      if (avs_read & ~ack_ff) begin
        rdata_ff <= rd_word;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sel_reg_ff <= 5'h0;
    end else if (wr_en && is_glb && fld == seq_pkg::G_SEL) begin
      sel_reg_ff <= avs_writedata[4:0];
    end
  end

  // ************************************************************
  // Entry table
  // ************************************************************
  seq_pkg::entry_type tbl_ff [seq_pkg::N_ENTRY];

  genvar g;
  generate
    for (g = 0; g < seq_pkg::N_ENTRY; g++) begin : gen_entry
      wire hit = wr_en & ~is_glb & a_idx == seq_pkg::IDX_W'(g);
      // Each entry keeps its own fields and reset defaults
      always_ff @(posedge clk) begin
        if (reset) begin
          tbl_ff[g] <= seq_pkg::ENTRY_RST;
        end else if (hit) begin
          case (fld)
            seq_pkg::F_POS: tbl_ff[g].target_position <= avs_writedata;
            seq_pkg::F_VEL: tbl_ff[g].velocity <= avs_writedata;
            seq_pkg::F_ACC: tbl_ff[g].start_accel <= avs_writedata;
            seq_pkg::F_DEC: tbl_ff[g].brake_accel <= avs_writedata;
            seq_pkg::F_CFG: begin
              tbl_ff[g].move_mode <= avs_writedata[seq_pkg::CFG_MODE +: 2];
              tbl_ff[g].launch_condition <= avs_writedata[seq_pkg::CFG_COND +: 2];
              tbl_ff[g].inmotion_reaction <= avs_writedata[seq_pkg::CFG_REACT +: 2];
              tbl_ff[g].switch_point_a <= avs_writedata[seq_pkg::CFG_SPA +: 3];
              tbl_ff[g].switch_point_b <= avs_writedata[seq_pkg::CFG_SPB +: 3];
              tbl_ff[g].repeat_count <= avs_writedata[seq_pkg::CFG_REP +: 8];
              tbl_ff[g].next_index <= avs_writedata[seq_pkg::CFG_NEXT +: 5];
            end
            seq_pkg::F_DLY: tbl_ff[g].launch_delay <= avs_writedata[15:0];
            default: ;
          endcase
        end
      end
    end
  endgenerate

  // ************************************************************
  // Sequencer state
  // ************************************************************
  seq_pkg::state_type state_ff;
  logic [seq_pkg::IDX_W-1:0] idx_ff;
  logic [7:0] rep_left_ff;
  logic [7:0] queued_ff;
  logic [MS_W-1:0] ms_cnt_ff;
  logic [15:0] dly_cnt_ff;
  seq_pkg::job_type job_ff;
  logic start_ff, update_ff, abort_ff;

  // Selected index: terminals or bus, binary weighted
  wire [seq_pkg::IDX_W-1:0] sel_idx = sel_reg_ff[seq_pkg::SEL_BUS_SRC] ?
      sel_reg_ff[3:0] : sel_s2_ff;
  wire release_evt = (rel_s2_ff & ~rel_d_ff) | bus_release;
  wire start_evt = (nst_s2_ff & ~nst_d_ff) | bus_next;
  seq_pkg::entry_type cur, sel_e, cont_e;
  assign cur = tbl_ff[idx_ff];
  assign sel_e = tbl_ff[sel_idx];

  // Repetitions go before the follow-on entry
  wire have_rep = rep_left_ff != 8'h0;
  wire has_next = ~cur.next_index[4];
  wire cont_any = have_rep | has_next;
  wire [seq_pkg::IDX_W-1:0] cont_idx = have_rep ? idx_ff : cur.next_index[3:0];
  assign cont_e = tbl_ff[cont_idx];
  wire [7:0] cont_rep = have_rep ? rep_left_ff - 8'h1 :
      (cont_e.move_mode == seq_pkg::RELATIVE_MODE ? cont_e.repeat_count : 8'h0);
  wire [7:0] sel_rep = sel_e.move_mode == seq_pkg::RELATIVE_MODE ?
      sel_e.repeat_count : 8'h0;
  // Condition 0 launches refer to where the axis stands, all other conditions to last target
  wire [31:0] cont_base = cur.launch_condition == seq_pkg::LAUNCH_ON_SWITCH ?
      actual_position : job_ff.target;

  // Delay expiry and launch decision while waiting
  wire ms_tick = ms_cnt_ff == MS_W'(MS_CYCLES - 1);
  wire dly_done = dly_cnt_ff >= cur.launch_delay;
  wire cond_switch = cur.launch_condition == seq_pkg::LAUNCH_ON_SWITCH;
  wire cond_delay = cur.launch_condition == seq_pkg::LAUNCH_AFTER_DELAY;
  wire cond_either = cur.launch_condition == seq_pkg::LAUNCH_SWITCH_OR_DELAY;
  wire cond_fly = cur.launch_condition == seq_pkg::LAUNCH_WITHOUT_STOP;
  wire wait_go = (cond_switch & start_evt)
      | (cond_delay & dly_done)
      | (cond_either & (start_evt | dly_done))
      | cond_fly | queued_ff != 8'h0;
  wire run_edge = state_ff == seq_pkg::ST_RUN & start_evt & ~target_reached;
  wire react_store = cur.inmotion_reaction == seq_pkg::REACT_STORE;
  wire react_next = cur.inmotion_reaction == seq_pkg::REACT_NEXT;

  // Outputs come straight from registers
  assign job = job_ff;
  assign job_start = start_ff;
  assign job_update = update_ff;
  assign job_abort = abort_ff;
  assign active_index = idx_ff;

  // Millisecond base and delay counter run only while waiting
  always_ff @(posedge clk) begin
    if (reset || state_ff != seq_pkg::ST_WAIT) begin
      ms_cnt_ff <= '0;
      dly_cnt_ff <= 16'h0;
    end else if (ms_tick) begin
      ms_cnt_ff <= '0;
      dly_cnt_ff <= (dly_cnt_ff == 16'hffff) ? dly_cnt_ff : dly_cnt_ff + 16'h1;
    end else begin
      ms_cnt_ff <= ms_cnt_ff + MS_W'(1);
    end
  end

  // Main sequence: release has top priority over everything running
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= seq_pkg::ST_IDLE;
      idx_ff <= '0;
      rep_left_ff <= 8'h0;
      queued_ff <= 8'h0;
      job_ff <= '0;
      {start_ff, update_ff, abort_ff} <= 3'h0;
    end else begin
      {start_ff, update_ff, abort_ff} <= 3'h0;
      if (release_evt) begin
        abort_ff <= state_ff != seq_pkg::ST_IDLE;
        idx_ff <= sel_idx;
        rep_left_ff <= sel_rep;
        queued_ff <= 8'h0;
        job_ff <= make_job(sel_e, actual_position, 1'b0, max_speed, max_accel);
        start_ff <= 1'b1;
        state_ff <= seq_pkg::ST_RUN;
      end else begin
        case (state_ff)
          seq_pkg::ST_IDLE: begin
            if (start_evt) begin
              idx_ff <= sel_idx;
              rep_left_ff <= sel_rep;
              job_ff <= make_job(sel_e, actual_position, 1'b0, max_speed, max_accel);
              start_ff <= 1'b1;
              state_ff <= seq_pkg::ST_RUN;
            end
          end
          seq_pkg::ST_RUN: begin
            if (target_reached) begin
              if (!cont_any) begin
                state_ff <= seq_pkg::ST_IDLE;
                queued_ff <= 8'h0;
              end else if (cond_fly) begin
                idx_ff <= cont_idx;
                rep_left_ff <= cont_rep;
                job_ff <= make_job(cont_e, job_ff.target, 1'b1, max_speed, max_accel);
                start_ff <= 1'b1;
              end else begin
                state_ff <= seq_pkg::ST_WAIT;
              end
            end else if (run_edge && react_store) begin
              job_ff.target <= job_ff.target + cur.target_position;
              queued_ff <= (queued_ff == 8'hff) ? queued_ff : queued_ff + 8'h1;
              update_ff <= 1'b1;
            end else if (run_edge && react_next) begin
              job_ff.target <= actual_position + cur.target_position;
              update_ff <= 1'b1;
            end
            // Reaction off: edges in motion fall through unused
          end
          seq_pkg::ST_WAIT: begin
            if (wait_go) begin
              idx_ff <= cont_idx;
              rep_left_ff <= cont_rep;
              queued_ff <= (queued_ff != 8'h0) ? queued_ff - 8'h1 : 8'h0;
              job_ff <= make_job(cont_e, cont_base, 1'b0, max_speed, max_accel);
              start_ff <= 1'b1;
              state_ff <= seq_pkg::ST_RUN;
            end
          end
          default: state_ff <= seq_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // ************************************************************
  // Read mux
  // ************************************************************
  seq_pkg::entry_type rd_e;
  assign rd_e = tbl_ff[a_idx];
  wire [31:0] cfg_word = (32'(rd_e.move_mode) << seq_pkg::CFG_MODE)
      | (32'(rd_e.launch_condition) << seq_pkg::CFG_COND)
      | (32'(rd_e.inmotion_reaction) << seq_pkg::CFG_REACT)
      | (32'(rd_e.switch_point_a) << seq_pkg::CFG_SPA)
      | (32'(rd_e.switch_point_b) << seq_pkg::CFG_SPB)
      | (32'(rd_e.repeat_count) << seq_pkg::CFG_REP)
      | (32'(rd_e.next_index) << seq_pkg::CFG_NEXT);
  // Status: state, active index, repetitions left, queued starts
  wire [31:0] stat_word = {rep_left_ff, queued_ff, 6'h0, 2'(state_ff),
      4'h0, idx_ff};

  // Unmapped words read as zero
  always_comb begin
    rd_word = 32'h0;
    if (is_glb) begin
      case (fld)
        seq_pkg::G_STAT: rd_word = stat_word;
        seq_pkg::G_TGT: rd_word = job_ff.target;
        seq_pkg::G_SEL: rd_word = {27'h0, sel_reg_ff};
        default: rd_word = 32'h0;
      endcase
    end else begin
      case (fld)
        seq_pkg::F_POS: rd_word = rd_e.target_position;
        seq_pkg::F_VEL: rd_word = rd_e.velocity;
        seq_pkg::F_ACC: rd_word = rd_e.start_accel;
        seq_pkg::F_DEC: rd_word = rd_e.brake_accel;
        seq_pkg::F_CFG: rd_word = cfg_word;
        seq_pkg::F_DLY: rd_word = {16'h0, rd_e.launch_delay};
        default: rd_word = 32'h0;
      endcase
    end
  end
endmodule

/* File: verif/seq_asserts.sv */
`timescale 1ns/1ps
module seq_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Bus handshake
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Job side
  input wire logic [31:0] max_speed,
  input wire logic [31:0] max_accel,
  input wire seq_pkg::job_type job,
  input wire logic job_start,
  input wire logic job_abort
);
  // ************************************************************
  // Port relations
  // ************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // One wait state, then the access completes
  chk_bus_one_wait: assert property ($rose(avs_read | avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("bus wait state wrong");
  chk_bus_idle_quiet: assert property (!(avs_read | avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without request");
  chk_abort_starts: assert property (job_abort |-> job_start)
    else $error("abort without new job");
  chk_speed_no_target: assert property (job_start &&
    job.move_mode == seq_pkg::MODE_SPEED |-> job.target == 32'h0)
    else $error("speed job carries target");
  chk_vel_sign_kept: assert property (job_start &&
    job.move_mode != seq_pkg::MODE_SPEED |-> !job.velocity[31])
    else $error("negative velocity outside speed mode");
  // Magnitude check covers both signs; it bounds the size only, so a wrong sign passes here
  chk_vel_clamped: assert property (job_start |->
    (job.velocity[31] ? -job.velocity : job.velocity) <= max_speed)
    else $error("velocity above maximum");
  chk_start_acc_range: assert property (job_start |->
    job.start_accel != 32'h0 && job.start_accel <= max_accel)
    else $error("start accel out of range");
  chk_brake_acc_range: assert property (job_start |->
    job.brake_accel != 32'h0 && job.brake_accel <= max_accel)
    else $error("brake accel out of range");
endmodule
bind driving_set_table_sequencer seq_asserts chk (.clk, .reset, .avs_read, .avs_write,
  .avs_waitrequest, .max_speed, .max_accel, .job, .job_start, .job_abort);

/* File: verif/profile_model.sv */
`timescale 1ns/1ps
module profile_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Job from the sequencer, travel time from the bench
  input wire seq_pkg::job_type job,
  input wire logic job_start,
  input wire logic [7:0] lag,
  // Motion feedback
  output logic target_reached,
  output logic [31:0] actual_position
);
  // ************************************************************
  // Travel
  // ************************************************************
  logic [7:0] left_ff;
  logic reached_ff;
  // Masked during a start, else the old arrival would count again
  assign target_reached = reached_ff & ~job_start;
  // Position jumps on arrival so relative bases stay exact
  always_ff @(posedge clk) begin
    if (reset) begin
      left_ff <= 8'h0;
      reached_ff <= 1'b0;
      actual_position <= 32'h0;
    end else if (job_start) begin
      left_ff <= lag;
      reached_ff <= 1'b0;
    end else if (left_ff == 8'h1) begin
      left_ff <= 8'h0;
      reached_ff <= 1'b1;
      actual_position <= job.target;
    end else if (left_ff != 8'h0) begin
      left_ff <= left_ff - 8'h1;
    end
  end
endmodule

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb;
  // ************************************************************
  // Harness
  // ************************************************************
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] avs_address = 8'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] entry_select_bit = 4'h0;
  logic entry_release_input = 1'b0;
  logic next_start_input = 1'b0;
  logic [31:0] max_speed = 32'h5dc;
  logic [31:0] max_accel = 32'h3000;
  logic [7:0] lag = 8'h5;
  logic [31:0] avs_readdata, actual_position, base;
  logic avs_waitrequest, target_reached, job_start, job_update, job_abort;
  logic [3:0] active_index;
  seq_pkg::job_type job;
  int n_mismatch = 0;
  int n_compared = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  // Short millisecond keeps delay waits brief
  driving_set_table_sequencer #(.MS_CYCLES(4)) dut (.clk, .reset, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .entry_select_bit, .entry_release_input, .next_start_input, .target_reached,
    .actual_position, .max_speed, .max_accel, .job, .job_start, .job_update,
    .job_abort, .active_index);
  profile_model model (.clk, .reset, .job, .job_start, .lag, .target_reached,
    .actual_position);
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic hang(input string nm);
    n_mismatch++;
    $display("[ERR] %s expected answer seen timeout", nm);
    final_report();
  endtask
  // Request held until the edge that sees waitrequest low
  task automatic bus(input logic wr, input int a, input logic [31:0] d,
      output logic [31:0] q);
    int k;
    @(posedge clk);
    avs_address <= 8'(a);
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (k == 20) hang("bus");
  endtask
  task automatic w(input int e, input int f, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, e * 8 + f, d, q);
  endtask
  task automatic rd(input string nm, input int e, input int f, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, e * 8 + f, 32'h0, q);
    cmp(nm, exp, q);
  endtask
  function automatic logic [31:0] cfg(logic [1:0] md, logic [1:0] cd, logic [7:0] rp,
      logic [4:0] nx, logic [2:0] sa);
    return {3'h0, nx, rp, 5'h0, sa, 4'h0, cd, md};
  endfunction
  // Two cycles high is enough for the pin synchroniser to see an edge
  task automatic pulse(input logic nxt);
    @(posedge clk);
    next_start_input <= nxt;
    entry_release_input <= !nxt;
    repeat (2) @(posedge clk);
    next_start_input <= 1'b0;
    entry_release_input <= 1'b0;
  endtask
  task automatic wait_job(input logic [3:0] ix, input logic [31:0] tg);
    int k;
    for (k = 0; k < 300; k++) begin
      @(negedge clk);
      if (job_start === 1'b1) break;
    end
    if (k == 300) hang("job start");
    cmp("index", 32'(ix), 32'(active_index));
    cmp("target", tg, job.target);
  endtask
  task automatic quiet(input int n);
    int hits = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (job_start !== 1'b0) hits++;
    end
    cmp("stray starts", 32'h0, 32'(hits));
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic s_defaults;
    rd("pos", 3, 0, 32'h0);
    rd("vel", 3, 1, 32'h3e8);
    rd("acc", 3, 2, 32'h2710);
    rd("dec", 3, 3, 32'h2710);
    rd("cfg", 3, 4, 32'h1f000001);
    rd("delay", 3, 5, 32'h0);
    w(3, 6, 32'h5a5a5a5a);
    rd("hole", 3, 6, 32'h0);
  endtask
  task automatic s_select;
    w(5, 0, 32'h100);
    w(5, 2, 32'h0);
    w(5, 4, cfg(2'h0, 2'h0, 8'h0, 5'h1f, 3'h4));
    entry_select_bit <= 4'h5;
    pulse(1'b0);
    wait_job(4'h5, 32'h100);
    cmp("sp a on", 32'h1, 32'(job.sp_a_en));
    cmp("sp a point", 32'h3, 32'(job.sp_a_point));
    cmp("sp b on", 32'h0, 32'(job.sp_b_en));
    cmp("acc zero", max_accel, job.start_accel);
  endtask
  task automatic s_chain;
    w(2, 0, 32'h10);
    w(2, 4, cfg(2'h1, 2'h1, 8'h2, 5'h7, 3'h0));
    w(2, 5, 32'h2);
    w(7, 0, 32'h77);
    w(7, 4, cfg(2'h0, 2'h0, 8'h0, 5'h1f, 3'h0));
    w(16, 3, 32'h12);
    base = actual_position;
    w(16, 0, 32'h1);
    wait_job(4'h2, base + 32'h10);
    wait_job(4'h2, base + 32'h20);
    wait_job(4'h2, base + 32'h30);
    wait_job(4'h7, 32'h77);
    quiet(60);
    w(16, 3, 32'h0);
  endtask
  task automatic s_switch;
    w(10, 0, 32'h30);
    w(4, 0, 32'h20);
    w(4, 4, cfg(2'h1, 2'h0, 8'h1, 5'h1f, 3'h0));
    lag <= 8'h28;
    entry_select_bit <= 4'h4;
    base = actual_position;
    pulse(1'b0);
    wait_job(4'h4, base + 32'h20);
    pulse(1'b1);
    quiet(60);
    @(posedge clk);
    next_start_input <= 1'b1;
    wait_job(4'h4, base + 32'h40);
    quiet(80);
    @(posedge clk);
    next_start_input <= 1'b0;
    entry_select_bit <= 4'ha;
    pulse(1'b1);
    wait_job(4'ha, base + 32'h70);
  endtask
  // A release while a job runs cuts it short
  task automatic s_abort;
    w(9, 0, 32'h999);
    w(9, 1, 32'hfffff830);
    w(9, 4, cfg(2'h2, 2'h0, 8'h0, 5'h1f, 3'h0));
    entry_select_bit <= 4'h5;
    pulse(1'b0);
    wait_job(4'h5, 32'h100);
    @(posedge clk);
    entry_select_bit <= 4'h9;
    pulse(1'b0);
    wait_job(4'h9, 32'h0);
    cmp("abort", 32'h1, 32'(job_abort));
    cmp("velocity", 32'hfffffa24, job.velocity);
  endtask
  // Stored edge launches at once, the last run on delay expiry
  task automatic s_either;
    w(6, 0, 32'h8);
    w(6, 5, 32'h3);
    w(6, 4, cfg(2'h1, 2'h2, 8'h2, 5'h1f, 3'h0) | 32'h10);
    entry_select_bit <= 4'h6;
    base = actual_position;
    pulse(1'b0);
    wait_job(4'h6, base + 32'h8);
    pulse(1'b1);
    quiet(4);
    cmp("stored", base + 32'h10, job.target);
    wait_job(4'h6, base + 32'h18);
    wait_job(4'h6, base + 32'h20);
  endtask
  task automatic s_no_stop;
    w(11, 0, 32'h30);
    w(11, 4, cfg(2'h1, 2'h3, 8'h1, 5'h1f, 3'h0));
    entry_select_bit <= 4'hb;
    base = actual_position;
    pulse(1'b0);
    wait_job(4'hb, base + 32'h30);
    wait_job(4'hb, base + 32'h60);
    cmp("on fly", 32'h1, 32'(job.on_fly));
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    s_defaults();
    s_select();
    s_chain();
    s_switch();
    s_abort();
    s_either();
    s_no_stop();
    final_report();
  end
endmodule
